// File: verilog/ssf_pkg.sv
package ssf_pkg;
   // Register byte offsets
   localparam logic [3:0] SSF_OFF_STATUS  = 4'h0;
   localparam logic [3:0] SSF_OFF_CONTROL = 4'h4;
   localparam logic [3:0] SSF_OFF_TXBUF   = 4'h8;
   localparam logic [3:0] SSF_OFF_RXBUF   = 4'hC;
   // Status bit positions
   localparam int SSF_TX_EMPTY  = 7;
   localparam int SSF_RX_FULL   = 6;
   localparam int SSF_OVERRUN   = 5;
   localparam int SSF_FRAMING   = 4;
   localparam int SSF_PARITY    = 3;
   localparam int SSF_TX_END    = 2;
   localparam int SSF_RX_MPB    = 1;
   localparam int SSF_TX_MPB    = 0;
   // Control bit positions
   localparam int SSF_CTL_TE    = 0;
   localparam int SSF_CTL_RE    = 1;
   localparam int SSF_CTL_SYNC  = 2;
   localparam int SSF_CTL_PAREN = 3;
   localparam int SSF_CTL_PODD  = 4;
   localparam int SSF_CTL_MP    = 5;
   // Reset values
   localparam logic [7:0] SSF_STATUS_RST  = 8'h84;
   localparam logic [7:0] SSF_CONTROL_RST = 8'h00;
   localparam logic [7:0] SSF_CONTROL_MSK = 8'h3F;
   // The five flags that obey read-then-write-0
   localparam logic [7:0] SSF_FLAG_MSK    = 8'hF8;
endpackage

// File: verilog/ssf_status.sv
`timescale 1ns/100ps
// How it works
// R1: Reset or standby loads status with 84h.
// R2: Manual reset leaves status bits untouched.
// R3: Writing 1 to a flag does nothing.
// R4: Write 0 clears only previously-read set flags.
// R5: Transmit-end and received multiprocessor bits read-only.
// R6: Transmit-empty set by reset, disable, buffer load.
// R7: Transmit-empty cleared by read-write0 or engine write.
// R8: Receive-full set on error-free received character.
// R9: Receive-full cleared by reset, read-write0, engine read.
// R10: Errors or receiver disable keep buffer, receive-full.
// R11: Overrun sets when receive-full still set; discard.
// R12: Overrun halts receive; sync mode blocks transmit.
// R13: Overrun cleared only reset, standby, read-write0.
// R14: Async framing error when stop bit is 0.
// R15: Only the first of two stop bits checked.
// R16: Framing error loads buffer, no receive-full, halts.
// R17: Framing flag cleared only reset, standby, read-write0.
// R18: Parity-error flag at bit 3.
// R19: Parity flag set on ones-count mismatch.
// R20: Transmit-end set on last bit if empty.
// R21: Per-flag qualifier armed by read, consumed by write.
module ssf_status
   import ssf_pkg::*;
(
   // Clock and resets
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       manual_rst_n_i,
   input  wire logic       standby_i,
   // Avalon-MM slave
   input  wire logic [3:0] address_i,
   input  wire logic       read_i,
   input  wire logic       write_i,
   input  wire logic [31:0] writedata_i,
   input  wire logic [3:0] byteenable_i,
   output logic [31:0]     readdata_o,
   output logic            waitrequest_o,
   // Receive engine
   input  wire logic       rx_done_i,
   input  wire logic [7:0] rx_data_i,
   input  wire logic       rx_parity_bit_i,
   input  wire logic       rx_stop_bit_i,
   input  wire logic       rx_mpb_i,
   output logic            rx_halt_o,
   // Transmit engine
   input  wire logic       tx_load_i,
   input  wire logic       tx_last_bit_i,
   output logic            tx_start_o,
   output logic            tx_inhibit_o,
   output logic [7:0]      tx_buffer_o,
   output logic            tx_multiproc_bit_o,
   // On-chip transfer engine
   input  wire logic       xfer_tx_write_i,
   input  wire logic [7:0] xfer_tx_data_i,
   input  wire logic       xfer_rx_read_i,
   output logic [7:0]      rx_buffer_o,
   output logic [7:0]      serial_status_o
);

   logic [7:0] serial_status;
   logic [7:0] serial_control;
   logic [7:0] tx_buffer;
   logic [7:0] rx_buffer;
   logic [7:3] armed;
   logic       ack;
   logic [31:0] readdata;
   logic [7:0] rd_mux;
   logic [2:0] man_sync;
   logic       man_rst_n;

   logic [7:0] next_status;
   logic [7:0] next_rx_buffer;

   // Address match shared by every register select
   function automatic logic addr_hit
   (
      input logic [3:0] addr,
      input logic [3:0] offset
   );
      return addr == offset;
   endfunction

   // Ones in data plus parity bit against the chosen sense
   function automatic logic parity_bad
   (
      input logic [7:0] data,
      input logic       pbit,
      input logic       odd
   );
      return (^{data, pbit}) != odd;
   endfunction

   // Manual reset comes from a pin: three stages, taken once the last two agree.
   // A low pulse shorter than two cycles is dropped as a glitch.
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         man_sync  <= 3'h7;
         man_rst_n <= 1'b1;
      end
      else
      begin
         man_sync <= {man_sync[1:0], manual_rst_n_i};
         if (man_sync[1] == man_sync[2])
         begin
            man_rst_n <= man_sync[2];
         end
      end
   end

   // Bus decode
   wire acc_done   = (read_i | write_i) & ack;
   wire rd_done    = read_i & ack;
   wire wr_done    = write_i & ack & byteenable_i[0];
   wire sel_status = addr_hit(address_i, SSF_OFF_STATUS);
   wire sel_ctl    = addr_hit(address_i, SSF_OFF_CONTROL);
   wire sel_tx     = addr_hit(address_i, SSF_OFF_TXBUF);
   wire sel_rx     = addr_hit(address_i, SSF_OFF_RXBUF);
   wire wr_status  = wr_done & sel_status;
   wire wr_ctl     = wr_done & sel_ctl;
   wire wr_txbuf   = wr_done & sel_tx;
   wire rd_status  = rd_done & sel_status;

   // One wait state on every access keeps read data registered
   assign waitrequest_o = (read_i | write_i) & ~ack;

   // Unmapped offsets read as zero
   always_comb
   begin
      if (sel_status)
      begin
         rd_mux = serial_status;
      end
      else if (sel_ctl)
      begin
         rd_mux = serial_control;
      end
      else if (sel_tx)
      begin
         rd_mux = tx_buffer;
      end
      else if (sel_rx)
      begin
         rd_mux = rx_buffer;
      end
      else
      begin
         rd_mux = 8'h00;
      end
   end

   // Mode decode
   wire te        = serial_control[SSF_CTL_TE];
   wire re        = serial_control[SSF_CTL_RE];
   wire sync_mode = serial_control[SSF_CTL_SYNC];
   wire par_en    = serial_control[SSF_CTL_PAREN];
   wire par_odd   = serial_control[SSF_CTL_PODD];
   wire mp_mode   = serial_control[SSF_CTL_MP];

   wire err_any   = serial_status[SSF_OVERRUN] | serial_status[SSF_FRAMING]
                  | serial_status[SSF_PARITY];
   assign rx_halt_o    = err_any; // R12
   assign tx_inhibit_o = sync_mode & err_any; // R12
   assign tx_start_o   = te & ~serial_status[SSF_TX_EMPTY] & ~tx_inhibit_o;

   // Reception accepted only while enabled and not halted
   wire rx_take   = rx_done_i & re & ~rx_halt_o; // R10
   // First stop bit only is presented by the receiver
   wire fer_hit   = ~sync_mode & ~rx_stop_bit_i; // R14 R15
   wire per_hit   = ~sync_mode & par_en
                  & parity_bad(rx_data_i, rx_parity_bit_i, par_odd); // R19
   wire ovr_hit   = serial_status[SSF_RX_FULL]; // R11

   // Outcome of an accepted character
   wire rx_load   = rx_take & ~ovr_hit; // R11 R16
   wire rx_mpb_ld = rx_load & mp_mode & ~sync_mode;

   // Software clear strobe per flag
   wire [7:0] sw_clr = {8{wr_status}} & {armed, 3'h0} & ~writedata_i[7:0]
                     & SSF_FLAG_MSK; // R3 R4

   // Software and engine events seen by the transmit flags
   wire tx_empty_clr = sw_clr[SSF_TX_EMPTY] | xfer_tx_write_i; // R7
   wire tx_end_set   = tx_last_bit_i & serial_status[SSF_TX_EMPTY]; // R20

   // One qualifier per clearable flag; bits 2:0 never arm.
   // Separate flops keep a clear local to the flag that was read.
   generate
      for (genvar gi = SSF_PARITY; gi <= SSF_TX_EMPTY; gi++)
      begin : g_arm
         logic next_arm;

         always_comb
         begin
            next_arm = armed[gi];
            if (rd_status)
            begin
               next_arm = serial_status[gi]; // R21
            end
            else if (wr_status)
            begin
               next_arm = 1'b0; // R21
            end
         end

         always_ff @(posedge mclk_i)
         begin
            if (!rst_n_i || standby_i || !man_rst_n)
            begin
               armed[gi] <= 1'b0; // R2
            end
            else
            begin
               armed[gi] <= next_arm;
            end
         end
      end
   endgenerate

   always_comb
   begin
      next_status = serial_status;
      // Clears first, so sets below win in the same cycle
      next_status = next_status & ~sw_clr; // R4 R13 R17
      if (tx_empty_clr)
      begin
         next_status[SSF_TX_EMPTY] = 1'b0; // R7
         next_status[SSF_TX_END]   = 1'b0;
      end
      if (xfer_rx_read_i)
      begin
         next_status[SSF_RX_FULL] = 1'b0; // R9
      end
      if (wr_status)
      begin
         next_status[SSF_TX_MPB] = writedata_i[SSF_TX_MPB]; // R5
      end
      // Sets
      if (tx_load_i)
      begin
         next_status[SSF_TX_EMPTY] = 1'b1; // R6
      end
      if (tx_end_set)
      begin
         next_status[SSF_TX_END] = 1'b1; // R20
      end
      if (!te)
      begin
         next_status[SSF_TX_EMPTY] = 1'b1; // R6
         next_status[SSF_TX_END]   = 1'b1; // R20
      end
      if (rx_take)
      begin
         if (ovr_hit)
         begin
            next_status[SSF_OVERRUN] = 1'b1; // R11
         end
         else
         begin
            if (fer_hit || per_hit)
            begin
               next_status[SSF_FRAMING] = next_status[SSF_FRAMING] | fer_hit; // R16
               next_status[SSF_PARITY]  = next_status[SSF_PARITY] | per_hit; // R18
            end
            else
            begin
               next_status[SSF_RX_FULL] = 1'b1; // R8
            end
            if (rx_mpb_ld)
            begin
               next_status[SSF_RX_MPB] = rx_mpb_i;
            end
         end
      end
   end

   // Receive buffer loads on any accepted character that does not overrun
   always_comb
   begin
      next_rx_buffer = rx_buffer;
      if (rx_load)
      begin
         next_rx_buffer = rx_data_i; // R11 R16
      end
   end

   // Status; standby acts like power-on for status.
   // Manual reset only freezes the flags, it never reloads them.
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i || standby_i)
      begin
         serial_status <= SSF_STATUS_RST; // R1 R9 R13 R17
      end
      else if (man_rst_n)
      begin
         serial_status <= next_status; // R2
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         rx_buffer <= 8'h00;
      end
      else
      begin
         rx_buffer <= next_rx_buffer;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         tx_buffer <= 8'h00;
      end
      else if (xfer_tx_write_i)
      begin
         tx_buffer <= xfer_tx_data_i;
      end
      else if (wr_txbuf)
      begin
         tx_buffer <= writedata_i[7:0];
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         serial_control <= SSF_CONTROL_RST;
      end
      else if (wr_ctl)
      begin
         serial_control <= writedata_i[7:0] & SSF_CONTROL_MSK;
      end
   end

   // Bus handshake
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         ack <= 1'b0;
      end
      else
      begin
         ack <= (read_i | write_i) & ~ack & ~acc_done;
      end
   end

   // Read data registered every cycle; the wait state lets it settle first
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         readdata <= 32'h0000_0000;
      end
      else
      begin
         readdata <= {24'h00_0000, rd_mux};
      end
   end

   assign readdata_o         = readdata;
   assign tx_buffer_o        = tx_buffer;
   assign rx_buffer_o        = rx_buffer;
   assign serial_status_o    = serial_status;
   assign tx_multiproc_bit_o = serial_status[SSF_TX_MPB];

endmodule

// File: tb/ssf_properties.sv
`timescale 1ns/100ps
module ssf_properties
   import ssf_pkg::*;
(
   // Watched ports
   input wire logic       mclk_i,
   input wire logic       rst_n_i,
   input wire logic       standby_i,
   input wire logic       read_i,
   input wire logic       write_i,
   input wire logic       rx_done_i,
   input wire logic       rx_stop_bit_i,
   input wire logic       tx_load_i,
   input wire logic       xfer_tx_write_i,
   input wire logic       xfer_rx_read_i,
   input wire logic       waitrequest_o,
   input wire logic       rx_halt_o,
   input wire logic [7:0] serial_status_o
);
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   wait_state_a:
      assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("wait state longer than one cycle");
   standby_load_a:
      assert property (standby_i |=> serial_status_o == SSF_STATUS_RST)
      else $error("standby did not load status");
   halt_level_a:
      assert property (rx_halt_o == (|serial_status_o[5:3]))
      else $error("halt does not follow error flags");
   full_rise_a:
      assert property ($rose(serial_status_o[6]) |-> $past(rx_done_i && rx_stop_bit_i))
      else $error("receive full set without clean character");
   overrun_rise_a:
      assert property ($rose(serial_status_o[5]) |-> $past(rx_done_i && serial_status_o[6]))
      else $error("overrun set without full buffer");
   frame_rise_a:
      assert property ($rose(serial_status_o[4]) |-> $past(rx_done_i && !rx_stop_bit_i))
      else $error("framing flag set without bad stop bit");
   empty_fall_a:
      assert property ($fell(serial_status_o[7]) |-> $past(write_i || xfer_tx_write_i))
      else $error("transmit empty cleared without write");
   empty_rise_a:
      assert property ($rose(serial_status_o[7]) |-> $past(tx_load_i || write_i || standby_i))
      else $error("transmit empty set without cause");
   full_fall_a:
      assert property ($fell(serial_status_o[6]) |-> $past(write_i || xfer_rx_read_i || standby_i))
      else $error("receive full cleared without cause");
endmodule

// File: tb/ssf_station.sv
`timescale 1ns/100ps
module ssf_station (
   // Line side toward the port
   input  wire logic       clk_i,
   output logic            rx_done_o,
   output logic [7:0]      rx_data_o,
   output logic            rx_parity_bit_o,
   output logic            rx_stop_bit_o,
   output logic            rx_mpb_o
);
   initial
   begin
      rx_done_o = 1'b0;
      rx_data_o = 8'h00;
      rx_parity_bit_o = 1'b0;
      rx_stop_bit_o = 1'b1;
      rx_mpb_o = 1'b0;
   end
   task send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
      @(posedge clk_i);
      rx_done_o       <= 1'b1;
      rx_data_o       <= d;
      rx_parity_bit_o <= ^d ^ bad_par;
      rx_stop_bit_o   <= !bad_stop;
      rx_mpb_o        <= 1'b0;
      @(posedge clk_i);
      // Released lines show the inverse so stale data cannot pass
      rx_done_o       <= 1'b0;
      rx_data_o       <= ~d;
      rx_parity_bit_o <= ~rx_parity_bit_o;
      rx_stop_bit_o   <= bad_stop;
      rx_mpb_o        <= 1'b1;
   endtask
endmodule

// File: tb/tb_ssf_status.sv
`timescale 1ns/100ps
module tb_ssf_status;
   import ssf_pkg::*;
   logic        mclk_i, rst_n_i, manual_rst_n_i, standby_i, read_i, write_i;
   logic        rx_done_i, rx_parity_bit_i, rx_stop_bit_i, rx_mpb_i, rx_halt_o;
   logic        tx_load_i, tx_last_bit_i, tx_start_o, tx_inhibit_o, tx_multiproc_bit_o;
   logic        xfer_tx_write_i, xfer_rx_read_i, waitrequest_o;
   logic [3:0]  address_i;
   logic [31:0] writedata_i, readdata_o;
   logic [7:0]  rx_data_i, tx_buffer_o, xfer_tx_data_i, rx_buffer_o, serial_status_o, q, d, d2;
   int          mismatches = 0;
   int          cmp_count = 0;
   int          cyc = 0;

   ssf_status DUT (.*, .byteenable_i(4'hF));
   ssf_station STN (.clk_i(mclk_i), .rx_done_o(rx_done_i), .rx_data_o(rx_data_i),
      .rx_parity_bit_o(rx_parity_bit_i), .rx_stop_bit_o(rx_stop_bit_i), .rx_mpb_o(rx_mpb_i));

   initial
   begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   task end_of_test;
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task acc(input logic w, input logic [3:0] a, input logic [7:0] v);
      int n;
      @(posedge mclk_i);
      read_i <= !w;
      write_i <= w;
      address_i <= a;
      writedata_i <= {24'h00_0000, v};
      n = 0;
      do
      begin
         @(posedge mclk_i);
         n++;
      end
      while (waitrequest_o !== 1'b0 && n < 50);
      q = readdata_o[7:0];
      read_i <= 1'b0;
      write_i <= 1'b0;
      @(negedge mclk_i);
   endtask
   task st(input logic [7:0] e);
      acc(1'b0, SSF_OFF_STATUS, 8'h00);
      chk("status", e, q);
   endtask
   // Standby, manual reset, load, last bit, engine write, engine read
   task tick(input logic [5:0] m);
      @(posedge mclk_i);
      {standby_i, manual_rst_n_i, tx_load_i, tx_last_bit_i, xfer_tx_write_i, xfer_rx_read_i} <= m;
      repeat (3) @(posedge mclk_i);
      {standby_i, manual_rst_n_i, tx_load_i, tx_last_bit_i, xfer_tx_write_i, xfer_rx_read_i} <= 6'h10;
      repeat (4) @(posedge mclk_i);
   endtask

   initial
   begin
      {rst_n_i, standby_i, read_i, write_i, tx_load_i, tx_last_bit_i} = 6'h00;
      {manual_rst_n_i, xfer_tx_write_i, xfer_rx_read_i} = 3'h4;
      address_i = 4'h0;
      writedata_i = 32'h0000_0000;
      xfer_tx_data_i = 8'h00;
      void'($urandom(32'h2abc_976a));
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      st(SSF_STATUS_RST);
      acc(1'b1, SSF_OFF_STATUS, 8'hFF);
      chk("tx mpb", 8'h01, {7'h00, tx_multiproc_bit_o});
      acc(1'b1, SSF_OFF_STATUS, 8'h00);
      st(8'h84);
      acc(1'b1, SSF_OFF_CONTROL, 8'h03);
      d = $urandom;
      xfer_tx_data_i <= d;
      tick(6'h12);
      st(8'h00);
      chk("tx buffer", d, tx_buffer_o);
      chk("tx start", 8'h01, {7'h00, tx_start_o});
      tick(6'h18);
      st(8'h80);
      tick(6'h14);
      st(8'h84);
      STN.send(d, 1'b0, 1'b0);
      st(8'hC4);
      d2 = $urandom;
      STN.send(d2, 1'b0, 1'b0);
      STN.send(~d, 1'b0, 1'b0);
      tick(6'h00);
      st(8'hE4);
      chk("rx buffer", d, rx_buffer_o);
      chk("rx halt", 8'h01, {7'h00, rx_halt_o});
      chk("tx inhibit", 8'h00, {7'h00, tx_inhibit_o});
      acc(1'b1, SSF_OFF_STATUS, 8'hDE);
      st(8'hC4);
      tick(6'h11);
      st(8'h84);
      STN.send(d2, 1'b0, 1'b1);
      st(8'h94);
      chk("rx buffer", d2, rx_buffer_o);
      acc(1'b1, SSF_OFF_STATUS, 8'hEE);
      st(8'h84);
      acc(1'b1, SSF_OFF_CONTROL, 8'h0B);
      STN.send(d, 1'b1, 1'b0);
      st(8'h8C);
      tick(6'h30);
      st(8'h84);
      acc(1'b0, 4'h2, 8'h00);
      chk("unmapped", 8'h00, q);
      end_of_test();
   end
endmodule

bind ssf_status ssf_properties u_prop (.mclk_i, .rst_n_i, .standby_i, .read_i, .write_i,
   .rx_done_i, .rx_stop_bit_i, .tx_load_i, .xfer_tx_write_i, .xfer_rx_read_i,
   .waitrequest_o, .rx_halt_o, .serial_status_o);
